// ===== logic/hdlc_fifo_params.svh
// Purpose: Constants for the HDLC FIFO and DMA handshake ends
// Assumes: One byte-wide FIFO half of 32 entries, two halves per direction
`ifndef HDLC_FIFO_PARAMS_SVH
`define HDLC_FIFO_PARAMS_SVH
`define HALF_DEPTH     6'h20
`define HALF_AW        5
`define FRAME_MAX      5'h11
`define COUNT_W        12
`define STATUS_OK      8'hA0
`endif

// ===== logic/hdlc_fifo_pkg.sv
package hdlc_fifo_pkg;
  typedef enum logic [1:0] {half_idle, half_ready, half_read} half_state_t;
  typedef logic [7:0] byte_t;
endpackage

// ===== logic/hdlc_dma_if.sv
`timescale 1ns/10ps
// Purpose: Host bus and DMA handshake between device end and host end
// Assumes: One channel of the two; instantiate twice for both
// Notes:   Bus cycle is one sys_clk cycle with strobe
interface hdlc_dma_if;
  logic       tx_dma_request;
  logic       rx_dma_request;
  logic       dma_acknowledge;
  logic       chip_select;
  logic       rd_strobe;
  logic       wr_strobe;
  logic       last_cycle;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport device (output tx_dma_request, rx_dma_request, rd_data,
                  input dma_acknowledge, chip_select, rd_strobe, wr_strobe, last_cycle, wr_data);
  modport host   (input tx_dma_request, rx_dma_request, rd_data,
                  output dma_acknowledge, chip_select, rd_strobe, wr_strobe, last_cycle, wr_data);
endinterface

// ===== logic/fifo_half_pair.sv
`timescale 1ns/10ps
// Purpose: 64-byte store of two 32-byte halves, one open to the bus
// Assumes: Writer fills the half that is not open, reader drains the open half
// Notes:   Half swaps once open half is empty and unclosed and other half is closed
`include "hdlc_fifo_params.svh"
module fifo_half_pair
  import hdlc_fifo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        flush,
  input  wire logic        wr_en,
  input  wire byte_t       wr_data,
  input  wire logic        wr_close,
  input  wire logic        rd_en,
  input  wire logic        rd_rewind,
  input  wire logic        release_half,
  output byte_t            rd_data,
  output logic             open_valid,
  output logic [5:0]       open_count,
  output logic [5:0]       fill_count,
  output logic             full
);
  byte_t                   mem [0:63];
  logic                    open_sel_reg, open_sel_next;
  logic [5:0]              cnt_reg [0:1];
  logic [5:0]              cnt_next [0:1];
  logic                    closed_reg [0:1];
  logic                    closed_next [0:1];
  logic [4:0]              rptr_reg, rptr_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    open_sel_next  = open_sel_reg;
    rptr_next      = rptr_reg;
    for (int i = 0; i < 2; i++) begin
      cnt_next[i]    = cnt_reg[i];
      closed_next[i] = closed_reg[i];
    end
    if (wr_en && cnt_reg[~open_sel_reg] != `HALF_DEPTH)
      cnt_next[~open_sel_reg] = cnt_reg[~open_sel_reg] + 6'h01;
    if (wr_close || (wr_en && cnt_reg[~open_sel_reg] == `HALF_DEPTH - 6'h01))
      closed_next[~open_sel_reg] = 1'b1;
    if (rd_en)
      rptr_next = rptr_reg + 5'h01;
    if (rd_rewind)
      rptr_next = 5'h00;
    if (release_half) begin
      cnt_next[open_sel_reg]    = 6'h00;
      closed_next[open_sel_reg] = 1'b0;
      rptr_next                 = 5'h00;
    end
    if ((release_half || !closed_reg[open_sel_reg]) && cnt_reg[open_sel_reg] == 6'h00
        && closed_next[~open_sel_reg])
      open_sel_next = ~open_sel_reg;
    if (flush) begin
      open_sel_next = 1'b0;
      rptr_next     = 5'h00;
      for (int i = 0; i < 2; i++) begin
        cnt_next[i]    = 6'h00;
        closed_next[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      open_sel_reg <= 1'b0;
      rptr_reg     <= 5'h00;
      for (int i = 0; i < 2; i++) begin
        cnt_reg[i]    <= 6'h00;
        closed_reg[i] <= 1'b0;
      end
    end else begin
      open_sel_reg <= open_sel_next;
      rptr_reg     <= rptr_next;
      for (int i = 0; i < 2; i++) begin
        cnt_reg[i]    <= cnt_next[i];
        closed_reg[i] <= closed_next[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en && cnt_reg[~open_sel_reg] != `HALF_DEPTH)
      mem[{~open_sel_reg, cnt_reg[~open_sel_reg][4:0]}] <= wr_data;
  end

  assign rd_data    = mem[{open_sel_reg, rptr_reg}];
  assign open_valid = closed_reg[open_sel_reg];
  assign open_count = cnt_reg[open_sel_reg];
  assign fill_count = cnt_reg[~open_sel_reg];
  assign full       = closed_reg[open_sel_reg] && cnt_reg[~open_sel_reg] == `HALF_DEPTH;
endmodule

// ===== logic/hdlc_host_end.sv
`timescale 1ns/10ps
// Purpose: DMA controller end for one channel, demand-mode transfers
// Assumes: Writes come from user data port, reads go to user sink
// Notes:   Uses acknowledge when use_ack is high, else addressed cycles
`include "hdlc_fifo_params.svh"
module hdlc_host_end
  import hdlc_fifo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        use_ack,
  input  wire byte_t       src_data,
  output logic             src_take,
  output byte_t            sink_data,
  output logic             sink_valid,
  hdlc_dma_if.host         bus
);
  logic                    rd_reg, rd_next, wr_reg, wr_next;
  logic [5:0]              n_reg, n_next;
  byte_t                   sd_reg, sd_next;
  logic                    sv_reg, sv_next;

  // ----------------------------------------
  // Cycle sequencer, one cycle per two clocks
  // ----------------------------------------
  always_comb begin
    rd_next = 1'b0;
    wr_next = 1'b0;
    n_next  = n_reg;
    sd_next = sd_reg;
    sv_next = rd_reg;
    if (rd_reg)
      sd_next = bus.rd_data;
    if (!rd_reg && !wr_reg) begin
      if (bus.rx_dma_request) begin
        rd_next = 1'b1;
        n_next  = n_reg + 6'h01;
      end else if (bus.tx_dma_request) begin
        wr_next = 1'b1;
        n_next  = n_reg + 6'h01;
      end else
        n_next = 6'h00;
    end
    if (n_next == `HALF_DEPTH + 6'h01)
      n_next = 6'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      n_reg  <= 6'h00;
      sd_reg <= 8'h00;
      sv_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      n_reg  <= n_next;
      sd_reg <= sd_next;
      sv_reg <= sv_next;
    end
  end

  assign bus.rd_strobe       = rd_reg;
  assign bus.wr_strobe       = wr_reg;
  assign bus.wr_data         = src_data;
  assign bus.dma_acknowledge = use_ack && (rd_reg || wr_reg);
  assign bus.chip_select     = !use_ack && (rd_reg || wr_reg);
  assign bus.last_cycle      = 1'b0;
  assign src_take            = wr_reg;
  assign sink_data           = sd_reg;
  assign sink_valid          = sv_reg;
endmodule

// ===== logic/hdlc_device_end.sv
`timescale 1ns/10ps
// Purpose: Device end: rx and tx FIFOs of one channel and DMA requests
// Assumes: Serial side presents bytes with strobes; one byte per cycle
// Notes:   Requests drop as the final cycle of a block ends
`include "hdlc_fifo_params.svh"
module hdlc_device_end
  import hdlc_fifo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        dma_mode,
  input  wire logic        addr_recog,
  input  wire logic        rx_block_complete_cmd,
  input  wire logic        tx_reset_cmd,
  input  wire logic [11:0] tx_byte_count,
  input  wire logic        tx_count_load,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_byte_valid,
  input  wire byte_t       rx_byte,
  input  wire logic        rx_is_address,
  input  wire logic        rx_frame_end,
  input  wire byte_t       rx_status,
  input  wire logic        tx_shift_ready,
  output byte_t            tx_shift_data,
  output logic             tx_shift_valid,
  output logic             rx_pool_full_irq,
  output logic             rx_message_end_irq,
  output logic             tx_pool_ready_irq,
  output logic             tx_underrun_irq,
  output logic             rx_frame_overflow_irq,
  hdlc_dma_if.device       bus
);
  logic                    rx_rd, tx_wr;
  byte_t                   rx_q, tx_q;
  logic                    rx_open, tx_open, rx_full, tx_full_unused;
  logic [5:0]              rx_ocnt, tx_ocnt, rx_fcnt, tx_fcnt;
  logic                    drq_r_reg, drq_r_next, drq_t_reg, drq_t_next;
  logic [5:0]              rn_reg, rn_next, tn_reg, tn_next;
  logic [11:0]             left_reg, left_next, sent_reg, sent_next;
  logic                    rx_st_reg, rx_st_next, rx_drop_reg, rx_drop_next;
  logic                    tsv_reg, tsv_next, ival_reg, ival_next;
  logic [4:0]              frames_reg, frames_next;
  logic [4:0]              irq_reg, irq_next;
  byte_t                   tsd_reg, tsd_next;
  logic                    rx_wr, rx_close, rx_rel, tx_rd, tx_rel, tx_close;
  byte_t                   rx_wdata;
  logic                    rx_rewind;
  logic                    end_fill_reg, end_fill_next, end_open_reg, end_open_next;

  assign rx_rd = bus.rd_strobe && (bus.dma_acknowledge || bus.chip_select);
  assign tx_wr = bus.wr_strobe && (bus.dma_acknowledge || bus.chip_select);
  assign rx_rewind = !dma_mode && rx_rd && rn_reg == rx_ocnt - 6'h01;

  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  always_comb begin
    rx_wr    = 1'b0;
    rx_wdata = rx_byte;
    rx_close = 1'b0;
    rx_drop_next = rx_drop_reg;
    rx_st_next   = 1'b0;
    frames_next  = frames_reg;
    if (rx_frame_start)
      rx_drop_next = rx_full || frames_reg == `FRAME_MAX;
    if (rx_byte_valid && !rx_drop_reg && !(addr_recog && rx_is_address))
      rx_wr = 1'b1;
    if (rx_frame_end && !rx_drop_reg) begin
      rx_st_next  = addr_recog;
      rx_close    = !addr_recog;
      frames_next = frames_reg + 5'h01;
    end
    if (rx_st_reg) begin
      rx_wr    = 1'b1;
      rx_wdata = rx_status;
      rx_close = 1'b1;
    end
    rx_rel = dma_mode ? (rx_rd && rn_reg == rx_ocnt - 6'h01) : rx_block_complete_cmd;
    if (rx_rel && frames_reg != 5'h00)
      frames_next = frames_next - 5'h01;
  end

  fifo_half_pair rx_fifo (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .flush        (1'b0),
    .wr_en        (rx_wr),
    .wr_data      (rx_wdata),
    .wr_close     (rx_close),
    .rd_en        (rx_rd),
    .rd_rewind    (rx_rewind),
    .release_half (rx_rel),
    .rd_data      (rx_q),
    .open_valid   (rx_open),
    .open_count   (rx_ocnt),
    .fill_count   (rx_fcnt),
    .full         (rx_full)
  );

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  assign tx_rd    = !tsv_reg && tx_open && tn_reg != tx_ocnt;
  assign tx_rel   = tx_open && tn_reg == tx_ocnt && !tsv_reg;
  assign tx_close = tx_wr && (tx_fcnt == `HALF_DEPTH - 6'h01 || left_reg == 12'h001);

  fifo_half_pair tx_fifo (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .flush        (tx_reset_cmd),
    .wr_en        (tx_wr),
    .wr_data      (bus.wr_data),
    .wr_close     (tx_close),
    .rd_en        (tx_rd),
    .rd_rewind    (1'b0),
    .release_half (tx_rel),
    .rd_data      (tx_q),
    .open_valid   (tx_open),
    .open_count   (tx_ocnt),
    .fill_count   (tx_fcnt),
    .full         (tx_full_unused)
  );

  // ----------------------------------------
  // Requests, counters and events
  // ----------------------------------------
  always_comb begin
    rn_next   = rx_rd ? rn_reg + 6'h01 : rn_reg;
    tn_next   = tx_rd ? tn_reg + 6'h01 : tn_reg;
    left_next = tx_wr && left_reg != 12'h000 ? left_reg - 12'h001 : left_reg;
    sent_next = sent_reg;
    tsv_next  = tsv_reg && !tx_shift_ready;
    tsd_next  = tsd_reg;
    ival_next = rx_open;
    irq_next  = 5'h00;
    if (rx_rel || rx_rewind)
      rn_next = 6'h00;
    if (tx_rel)
      tn_next = 6'h00;
    if (tx_rd) begin
      tsv_next = 1'b1;
      tsd_next = tx_q;
    end
    if (tsv_reg && tx_shift_ready)
      sent_next = sent_reg + 12'h001;
    if (tx_count_load) begin
      left_next = tx_byte_count;
      sent_next = 12'h000;
    end
    // Level request for the open rx half; off at end of final read
    drq_r_next = dma_mode && rx_open && !(rx_rd && rn_reg == rx_ocnt - 6'h01);
    // Tx request while bytes remain and the tx FIFO is not full
    drq_t_next = dma_mode && left_reg != 12'h000 && !tx_full_unused
                 && !(tx_wr && (tx_fcnt == `HALF_DEPTH - 6'h01 || left_reg == 12'h001));
    irq_next[0] = !dma_mode && rx_open && !ival_reg;
    // Frame end follows its half from collecting to open
    end_fill_next = end_fill_reg || rx_close;
    end_open_next = end_open_reg;
    if (rx_open && !ival_reg) begin
      end_open_next = end_fill_reg;
      end_fill_next = rx_close;
    end
    if (rx_rel)
      end_open_next = 1'b0;
    irq_next[1] = rx_rel && dma_mode && end_open_reg;
    irq_next[2] = (tx_rel && !dma_mode) || tx_reset_cmd;
    irq_next[3] = dma_mode && !tx_open && !tsv_reg && sent_reg != 12'h000
                  && left_reg != 12'h000 && tx_fcnt == 6'h00;
    irq_next[4] = rx_frame_start && (rx_full || frames_reg == `FRAME_MAX);
    if (tx_reset_cmd) begin
      tn_next   = 6'h00;
      tsv_next  = 1'b0;
      left_next = 12'h000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drq_r_reg   <= 1'b0;
      drq_t_reg   <= 1'b0;
      rn_reg      <= 6'h00;
      tn_reg      <= 6'h00;
      left_reg    <= 12'h000;
      sent_reg    <= 12'h000;
      rx_st_reg   <= 1'b0;
      rx_drop_reg <= 1'b0;
      tsv_reg     <= 1'b0;
      tsd_reg     <= 8'h00;
      ival_reg    <= 1'b0;
      frames_reg  <= 5'h00;
      irq_reg     <= 5'h00;
      end_fill_reg <= 1'b0;
      end_open_reg <= 1'b0;
    end else begin
      drq_r_reg   <= drq_r_next;
      drq_t_reg   <= drq_t_next;
      rn_reg      <= rn_next;
      tn_reg      <= tn_next;
      left_reg    <= left_next;
      sent_reg    <= sent_next;
      rx_st_reg   <= rx_st_next;
      rx_drop_reg <= rx_drop_next;
      tsv_reg     <= tsv_next;
      tsd_reg     <= tsd_next;
      ival_reg    <= ival_next;
      frames_reg  <= frames_next;
      irq_reg     <= irq_next;
      end_fill_reg <= end_fill_next;
      end_open_reg <= end_open_next;
    end
  end

  assign bus.rx_dma_request    = drq_r_reg;
  assign bus.tx_dma_request    = drq_t_reg;
  assign bus.rd_data           = rx_q;
  assign tx_shift_data         = tsd_reg;
  assign tx_shift_valid        = tsv_reg;
  assign rx_pool_full_irq      = irq_reg[0];
  assign rx_message_end_irq    = irq_reg[1];
  assign tx_pool_ready_irq     = irq_reg[2];
  assign tx_underrun_irq       = irq_reg[3];
  assign rx_frame_overflow_irq = irq_reg[4];
endmodule

// ===== dv/hdlc_dma_chk.sv
`timescale 1ns/10ps
// Purpose: Concurrent checks on the DMA handshake between the two ends
// Assumes: One sys_clk domain, rst_n synchronous active low
// Notes:   Block counters count strobes while a request is up
module hdlc_dma_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tx_dma_request,
  input wire logic rx_dma_request,
  input wire logic dma_acknowledge,
  input wire logic chip_select,
  input wire logic rd_strobe,
  input wire logic wr_strobe
);
  // ----------------------------------------
  // Block counters
  // ----------------------------------------
  logic [5:0] rd_cnt_reg;
  logic [5:0] rd_cnt_next;
  logic [5:0] wr_cnt_reg;
  logic [5:0] wr_cnt_next;
  always_comb begin
    rd_cnt_next = 6'h00;
    wr_cnt_next = 6'h00;
    if (rx_dma_request) begin
      rd_cnt_next = rd_cnt_reg + {5'h00, rd_strobe};
    end
    if (tx_dma_request) begin
      wr_cnt_next = wr_cnt_reg + {5'h00, wr_strobe};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_cnt_reg <= 6'h00;
      wr_cnt_reg <= 6'h00;
    end else begin
      rd_cnt_reg <= rd_cnt_next;
      wr_cnt_reg <= wr_cnt_next;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  AST_REQ_RESET: assert property ($rose(rst_n) |-> !rx_dma_request && !tx_dma_request)
    else $error("request high after reset");
  AST_RD_ON_RX: assert property (rd_strobe |-> rx_dma_request)
    else $error("read without rx request");
  AST_WR_ON_TX: assert property (wr_strobe |-> tx_dma_request)
    else $error("write without tx request");
  AST_ONE_DIR: assert property (!(rd_strobe && wr_strobe))
    else $error("read and write together");
  AST_SPACING: assert property ((rd_strobe || wr_strobe) |=> !rd_strobe && !wr_strobe)
    else $error("bus cycles too close");
  AST_QUALIFIED: assert property ((rd_strobe || wr_strobe) |-> dma_acknowledge || chip_select)
    else $error("unselected bus cycle");
  AST_RX_HOLD: assert property (rx_dma_request && !rd_strobe && !$past(rd_strobe) |=> rx_dma_request)
    else $error("rx request dropped without read");
  AST_TX_HOLD: assert property (tx_dma_request && !wr_strobe && !$past(wr_strobe) |=> tx_dma_request)
    else $error("tx request dropped without write");
  AST_RX_BLOCK_END: assert property (rd_strobe && rd_cnt_reg == 6'h1f |-> ##[1:2] !rx_dma_request)
    else $error("rx request kept after block");
  AST_TX_BLOCK_END: assert property (wr_strobe && wr_cnt_reg == 6'h1f |-> ##[1:2] !tx_dma_request)
    else $error("tx request kept after block");
  AST_BLOCK_MAX: assert property (rd_cnt_reg <= 6'h20 && wr_cnt_reg <= 6'h20)
    else $error("block longer than a half");
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/10ps
// Purpose: Drives both ends joined by one interface and checks data
// Assumes: Host end serves requests at once; serial side paced slowly
// Notes:   Pulse outputs are counted on every rising clock edge
module tb_top import hdlc_fifo_pkg::*; ;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        dma_mode = 1'b0;
  logic        addr_recog = 1'b0;
  logic        use_ack = 1'b1;
  logic        rx_block_complete_cmd = 1'b0;
  logic        tx_reset_cmd = 1'b0;
  logic        tx_count_load = 1'b0;
  logic        rx_frame_start = 1'b0;
  logic        rx_byte_valid = 1'b0;
  logic        rx_is_address = 1'b0;
  logic        rx_frame_end = 1'b0;
  logic [11:0] tx_byte_count = 12'h000;
  byte_t       rx_byte = 8'h00;
  byte_t       rx_status = 8'h5a;
  logic [7:0]  src_ptr = 8'h00;
  logic [2:0]  pace = 3'h0;
  logic        rq_prev = 1'b0;
  logic        tx_shift_ready, tx_shift_valid, src_take, sink_valid;
  byte_t       src_data, sink_data, tx_shift_data;
  logic        rx_pool_full_irq, rx_message_end_irq, tx_pool_ready_irq, tx_underrun_irq, rx_frame_overflow_irq;
  byte_t       sink_q[$];
  byte_t       tx_q[$];
  int          num_errors = 0;
  int          total_checks = 0;
  int          pf_n = 0, me_n = 0, ovf_n = 0, xpr_n = 0, xdu_n = 0, rq_n = 0, rd_n = 0, me_rd = 0;
  int          c0, c1, c2, n;
  hdlc_dma_if bus_if ();
  hdlc_device_end hdlc_device_end_inst (.sys_clk, .rst_n, .dma_mode, .addr_recog, .rx_block_complete_cmd,
    .tx_reset_cmd, .tx_byte_count, .tx_count_load, .rx_frame_start, .rx_byte_valid, .rx_byte, .rx_is_address,
    .rx_frame_end, .rx_status, .tx_shift_ready, .tx_shift_data, .tx_shift_valid, .rx_pool_full_irq,
    .rx_message_end_irq, .tx_pool_ready_irq, .tx_underrun_irq, .rx_frame_overflow_irq, .bus(bus_if));
  hdlc_host_end hdlc_host_end_inst (.sys_clk, .rst_n, .use_ack, .src_data, .src_take, .sink_data,
    .sink_valid, .bus(bus_if));
  hdlc_dma_chk hdlc_dma_chk_inst (.sys_clk, .rst_n, .tx_dma_request(bus_if.tx_dma_request),
    .rx_dma_request(bus_if.rx_dma_request), .dma_acknowledge(bus_if.dma_acknowledge),
    .chip_select(bus_if.chip_select), .rd_strobe(bus_if.rd_strobe), .wr_strobe(bus_if.wr_strobe));
  // ----------------------------------------
  // Clock, pacing and monitors
  // ----------------------------------------
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  assign tx_shift_ready = (pace == 3'h0);
  assign src_data = 8'h40 + src_ptr;
  always @(posedge sys_clk) begin
    pace <= #2 pace + 3'h1;
    if (src_take === 1'b1) src_ptr <= #2 src_ptr + 8'h01;
    if (sink_valid === 1'b1) sink_q.push_back(sink_data);
    if (tx_shift_valid === 1'b1 && tx_shift_ready === 1'b1) tx_q.push_back(tx_shift_data);
    if (bus_if.rd_strobe === 1'b1) rd_n++;
    if (rx_pool_full_irq === 1'b1) pf_n++;
    if (rx_message_end_irq === 1'b1) me_rd = rd_n;
    if (rx_message_end_irq === 1'b1) me_n++;
    if (rx_frame_overflow_irq === 1'b1) ovf_n++;
    if (tx_pool_ready_irq === 1'b1) xpr_n++;
    if (tx_underrun_irq === 1'b1) xdu_n++;
    if (bus_if.rx_dma_request === 1'b1 && rq_prev === 1'b0) rq_n++;
    rq_prev = bus_if.rx_dma_request;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int cyc);
    repeat (cyc) @(posedge sys_clk);
    #2;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_q(input logic tx, input int cnt);
    for (int i = 0; i < 4000; i++) begin
      if ((tx ? tx_q.size() : sink_q.size()) >= cnt) return;
      tick(1);
    end
    num_errors++;
    $display("timeout at %0t", $time);
    wrap_up();
  endtask
  task automatic reset_dut;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    sink_q.delete();
    tx_q.delete();
  endtask
  task automatic send_frame(input int len, input int base, input logic addr, input logic close);
    rx_frame_start = 1'b1;
    tick(1);
    rx_frame_start = 1'b0;
    for (int i = 0; i < len; i++) begin
      rx_byte = 8'(base + i);
      rx_is_address = addr && (i == 0);
      rx_byte_valid = 1'b1;
      tick(1);
      rx_byte_valid = 1'b0;
      tick(2);
    end
    rx_is_address = 1'b0;
    rx_frame_end = close;
    tick(1);
    rx_frame_end = 1'b0;
    tick(1);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(1);
    check(16'(bus_if.rx_dma_request), 16'h0000);
    check(16'(bus_if.tx_dma_request), 16'h0000);
    $display("test reset done");
    c0 = pf_n;
    c1 = rq_n;
    send_frame(32, 0, 1'b0, 1'b0);
    tick(4);
    check(16'(pf_n - c0), 16'h0001);
    check(16'(rq_n - c1), 16'h0000);
    c0 = xpr_n;
    tx_reset_cmd = 1'b1;
    tick(1);
    tx_reset_cmd = 1'b0;
    tick(4);
    check(16'(xpr_n - c0), 16'h0001);
    $display("test interrupt mode done");
    reset_dut();
    addr_recog = 1'b1;
    c0 = ovf_n;
    repeat (17) send_frame(2, 48, 1'b1, 1'b1);
    check(16'(ovf_n - c0), 16'h0000);
    send_frame(0, 0, 1'b0, 1'b0);
    tick(4);
    check(16'(ovf_n - c0), 16'h0001);
    $display("test short frames done");
    reset_dut();
    dma_mode = 1'b1;
    addr_recog = 1'b0;
    for (int k = 0; k < 2; k++) begin
      use_ack = (k == 0);
      n = (k == 0) ? 40 : 72;
      c0 = rq_n;
      c1 = me_n;
      c2 = rd_n;
      send_frame(n, 16 * k, 1'b0, 1'b1);
      wait_q(1'b0, n);
      tick(100);
      check(16'(sink_q.size()), 16'(n));
      for (int i = 0; i < n; i++) check(16'(sink_q[i]), 16'(16 * k + i));
      check(16'(rq_n - c0 >= (n + 31) / 32), 16'h0001);
      check(16'(me_n - c1), 16'h0001);
      check(16'(me_rd - c2 >= n), 16'h0001);
      sink_q.delete();
    end
    $display("test dma receive done");
    addr_recog = 1'b1;
    c1 = me_n;
    send_frame(4, 80, 1'b1, 1'b1);
    wait_q(1'b0, 4);
    tick(60);
    check(16'(sink_q.size()), 16'h0004);
    for (int i = 0; i < 3; i++) check(16'(sink_q[i]), 16'(81 + i));
    check(16'(sink_q[3]), 16'(rx_status));
    check(16'(me_n - c1), 16'h0001);
    $display("test address frame done");
    c0 = xdu_n;
    tx_byte_count = 12'h028;
    tx_count_load = 1'b1;
    tick(1);
    tx_count_load = 1'b0;
    wait_q(1'b1, 40);
    tick(200);
    check(16'(tx_q.size()), 16'h0028);
    for (int i = 0; i < 40; i++) check(16'(tx_q[i]), 16'(64 + i));
    check(16'(xdu_n - c0), 16'h0000);
    $display("test dma transmit done");
    wrap_up();
  end
endmodule
